// ===== rtl/cmpc_params.svh
// How it works
// - Control register layout fixed, resets zero.
// - Mode bit 5 enables rising interrupt.
// - Mode bit 4 enables falling interrupt.
// - Mode bits 7-6, 3-2 read zero.
// - Mode bits 1-0 drive response time.
// - Speed code 0 fastest; resets to 2.
// - Edges set sticky flags; software clears.
// - Enable bit turns comparator on/off.
// - Result bit shows current comparator output.
// - Hysteresis fields set independently per direction.
`ifndef CMPC_PARAMS_SVH
`define CMPC_PARAMS_SVH

// Register addresses on the special function register port.
`define CMPC_CTRL_ADDR 8'h9C
`define CMPC_MODE_ADDR 8'h9D

// Reset images of the two registers.
`define CMPC_CTRL_RST 8'h00
`define CMPC_MODE_RST 8'h02

// Control register field positions.
`define CMPC_ON_BIT 7
`define CMPC_RESULT_BIT 6
`define CMPC_RISE_BIT 5
`define CMPC_FALL_BIT 4
`define CMPC_POS_HI 3
`define CMPC_POS_LO 2
`define CMPC_NEG_HI 1
`define CMPC_NEG_LO 0

// Mode register field positions.
`define CMPC_RIE_BIT 5
`define CMPC_FIE_BIT 4
`define CMPC_SPD_HI 1
`define CMPC_SPD_LO 0

`endif

// ===== rtl/cmpc_pkg.sv
package cmpc_pkg;

   // Response time selection, fastest to lowest power.
   typedef enum logic [1:0] {
      CMPC_SPEED_FAST = 2'b00,
      CMPC_SPEED_MID1 = 2'b01,
      CMPC_SPEED_MID2 = 2'b10,
      CMPC_SPEED_LOWP = 2'b11
   } cmpc_speed_type;

   // Hysteresis amount for one direction.
   typedef enum logic [1:0] {
      CMPC_HYST_OFF = 2'b00,
      CMPC_HYST_5MV = 2'b01,
      CMPC_HYST_10MV = 2'b10,
      CMPC_HYST_20MV = 2'b11
   } cmpc_hyst_type;

endpackage : cmpc_pkg

// ===== rtl/cmpc_regs.sv
`include "cmpc_params.svh"

module cmpc_regs
   import cmpc_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic [7:0] I_SFR_ADDR,
   input wire logic I_SFR_WR,
   input wire logic I_SFR_RD,
   input wire logic [7:0] I_SFR_WDATA,
   input wire logic I_CMP_RAW,
   output logic [7:0] O_SFR_RDATA,
   output logic O_CMP_ON,
   output logic [1:0] O_POS_HYST_SEL,
   output logic [1:0] O_NEG_HYST_SEL,
   output logic [1:0] O_RESPONSE_SPEED_SEL,
   output logic O_IRQ
);

   localparam logic [7:0] CTRL_RST = `CMPC_CTRL_RST;
   localparam logic [7:0] MODE_RST = `CMPC_MODE_RST;

   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic cmp_on_r;
   logic cmp_on_nxt;
   logic rise_seen_flag_r;
   logic rise_seen_flag_nxt;
   logic fall_seen_flag_r;
   logic fall_seen_flag_nxt;
   cmpc_hyst_type pos_hyst_sel_r;
   cmpc_hyst_type pos_hyst_sel_nxt;
   cmpc_hyst_type neg_hyst_sel_r;
   cmpc_hyst_type neg_hyst_sel_nxt;
   logic rise_irq_en_r;
   logic rise_irq_en_nxt;
   logic fall_irq_en_r;
   logic fall_irq_en_nxt;
   cmpc_speed_type response_speed_sel_r;
   cmpc_speed_type response_speed_sel_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic wr_ctrl;
   logic wr_mode;
   logic rise_edge;
   logic fall_edge;

   // Address match against one register, used for reads and writes.
   function automatic logic cmpc_hit(input logic [7:0] addr,
                                     input logic [7:0] reg_addr);
      cmpc_hit = (addr == reg_addr);
   endfunction : cmpc_hit

   // The analog result is asynchronous, so it is brought in through two
   // flip-flops; only the second stage is ever looked at.
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync1_r <= I_CMP_RAW;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // Write decode and edge detection on the synchronised result.
   assign wr_ctrl = I_SFR_WR && cmpc_hit(I_SFR_ADDR, `CMPC_CTRL_ADDR);
   assign wr_mode = I_SFR_WR && cmpc_hit(I_SFR_ADDR, `CMPC_MODE_ADDR);
   assign rise_edge = sync2_r && !prev_r;
   assign fall_edge = !sync2_r && prev_r;

   // Next register values. A flag set by an edge beats a software write in
   // the same cycle, so an event arriving during a clear is never lost.
   always_comb begin
      cmp_on_nxt = cmp_on_r;
      rise_seen_flag_nxt = rise_seen_flag_r;
      fall_seen_flag_nxt = fall_seen_flag_r;
      pos_hyst_sel_nxt = pos_hyst_sel_r;
      neg_hyst_sel_nxt = neg_hyst_sel_r;
      rise_irq_en_nxt = rise_irq_en_r;
      fall_irq_en_nxt = fall_irq_en_r;
      response_speed_sel_nxt = response_speed_sel_r;
      rdata_nxt = rdata_r;
      if (wr_ctrl) begin
         cmp_on_nxt = I_SFR_WDATA[`CMPC_ON_BIT];
         rise_seen_flag_nxt = I_SFR_WDATA[`CMPC_RISE_BIT];
         fall_seen_flag_nxt = I_SFR_WDATA[`CMPC_FALL_BIT];
         pos_hyst_sel_nxt = cmpc_hyst_type'(
            I_SFR_WDATA[`CMPC_POS_HI:`CMPC_POS_LO]);
         neg_hyst_sel_nxt = cmpc_hyst_type'(
            I_SFR_WDATA[`CMPC_NEG_HI:`CMPC_NEG_LO]);
      end
      if (wr_mode) begin
         rise_irq_en_nxt = I_SFR_WDATA[`CMPC_RIE_BIT];
         fall_irq_en_nxt = I_SFR_WDATA[`CMPC_FIE_BIT];
         response_speed_sel_nxt = cmpc_speed_type'(
            I_SFR_WDATA[`CMPC_SPD_HI:`CMPC_SPD_LO]);
      end
      if (rise_edge) begin
         rise_seen_flag_nxt = 1'b1;
      end
      if (fall_edge) begin
         fall_seen_flag_nxt = 1'b1;
      end
      if (I_SFR_RD) begin
         rdata_nxt = 8'h00;
         if (cmpc_hit(I_SFR_ADDR, `CMPC_CTRL_ADDR)) begin
            rdata_nxt[`CMPC_ON_BIT] = cmp_on_r;
            rdata_nxt[`CMPC_RESULT_BIT] = sync2_r;
            rdata_nxt[`CMPC_RISE_BIT] = rise_seen_flag_r;
            rdata_nxt[`CMPC_FALL_BIT] = fall_seen_flag_r;
            rdata_nxt[`CMPC_POS_HI:`CMPC_POS_LO] = pos_hyst_sel_r;
            rdata_nxt[`CMPC_NEG_HI:`CMPC_NEG_LO] = neg_hyst_sel_r;
         end else if (cmpc_hit(I_SFR_ADDR, `CMPC_MODE_ADDR)) begin
            // Unused pairs stay zero from the clear above.
            rdata_nxt[`CMPC_RIE_BIT] = rise_irq_en_r;
            rdata_nxt[`CMPC_FIE_BIT] = fall_irq_en_r;
            rdata_nxt[`CMPC_SPD_HI:`CMPC_SPD_LO] = response_speed_sel_r;
         end
      end
   end

   // Register stage with the documented reset images.
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         cmp_on_r <= CTRL_RST[`CMPC_ON_BIT];
         rise_seen_flag_r <= CTRL_RST[`CMPC_RISE_BIT];
         fall_seen_flag_r <= CTRL_RST[`CMPC_FALL_BIT];
         pos_hyst_sel_r <= cmpc_hyst_type'(
            CTRL_RST[`CMPC_POS_HI:`CMPC_POS_LO]);
         neg_hyst_sel_r <= cmpc_hyst_type'(
            CTRL_RST[`CMPC_NEG_HI:`CMPC_NEG_LO]);
         rise_irq_en_r <= MODE_RST[`CMPC_RIE_BIT];
         fall_irq_en_r <= MODE_RST[`CMPC_FIE_BIT];
         response_speed_sel_r <= cmpc_speed_type'(
            MODE_RST[`CMPC_SPD_HI:`CMPC_SPD_LO]);
         rdata_r <= 8'h00;
      end else begin
         cmp_on_r <= cmp_on_nxt;
         rise_seen_flag_r <= rise_seen_flag_nxt;
         fall_seen_flag_r <= fall_seen_flag_nxt;
         pos_hyst_sel_r <= pos_hyst_sel_nxt;
         neg_hyst_sel_r <= neg_hyst_sel_nxt;
         rise_irq_en_r <= rise_irq_en_nxt;
         fall_irq_en_r <= fall_irq_en_nxt;
         response_speed_sel_r <= response_speed_sel_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs to the analog core and the interrupt handler. The request is
   // a level that stays up until software clears the flag or the enable.
   assign O_SFR_RDATA = rdata_r;
   assign O_CMP_ON = cmp_on_r;
   assign O_POS_HYST_SEL = pos_hyst_sel_r;
   assign O_NEG_HYST_SEL = neg_hyst_sel_r;
   assign O_RESPONSE_SPEED_SEL = response_speed_sel_r;
   assign O_IRQ = (rise_seen_flag_r && rise_irq_en_r) ||
                  (fall_seen_flag_r && fall_irq_en_r);

   // Both registers hold their reset images once reset is released.
   property p_reset_image;
      @(posedge I_CLOCK) disable iff (I_RST)
      $fell(I_RST) |-> !O_CMP_ON && !rise_seen_flag_r && !fall_seen_flag_r
         && O_POS_HYST_SEL == 2'h0 && O_NEG_HYST_SEL == 2'h0
         && O_RESPONSE_SPEED_SEL == 2'h2 && !O_IRQ;
   endproperty
   a_reset_image: assert property (p_reset_image)
      else $error("Register reset image wrong.");

   // A rising result sets the rising flag within three cycles: two
   // synchroniser stages and the flag stage.
   property p_rise_sets;
      @(posedge I_CLOCK) disable iff (I_RST)
      $rose(I_CMP_RAW) |-> ##[1:3] rise_seen_flag_r;
   endproperty
   a_rise_sets: assert property (p_rise_sets)
      else $error("Rising edge did not set its flag.");

   // A falling result sets the falling flag within three cycles.
   property p_fall_sets;
      @(posedge I_CLOCK) disable iff (I_RST)
      $fell(I_CMP_RAW) |-> ##[1:3] fall_seen_flag_r;
   endproperty
   a_fall_sets: assert property (p_fall_sets)
      else $error("Falling edge did not set its flag.");

   // A set flag stays set until a control write.
   property p_flag_sticky;
      @(posedge I_CLOCK) disable iff (I_RST)
      (rise_seen_flag_r && !wr_ctrl) |=> rise_seen_flag_r;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("Rising flag dropped without a write.");

   // Writing zero clears a flag when no edge arrives.
   property p_flag_clear;
      @(posedge I_CLOCK) disable iff (I_RST)
      (wr_ctrl && !I_SFR_WDATA[`CMPC_FALL_BIT] && !fall_edge)
         |=> !fall_seen_flag_r;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("Falling flag not cleared by write.");

   // Control writes steer enable and hysteresis outputs.
   property p_ctrl_write;
      @(posedge I_CLOCK) disable iff (I_RST)
      wr_ctrl |=> O_CMP_ON == $past(I_SFR_WDATA[7])
         && O_POS_HYST_SEL == $past(I_SFR_WDATA[3:2])
         && O_NEG_HYST_SEL == $past(I_SFR_WDATA[1:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("Control write not applied.");

   // Mode writes steer interrupt enables and the response time.
   property p_mode_write;
      @(posedge I_CLOCK) disable iff (I_RST)
      wr_mode |=> rise_irq_en_r == $past(I_SFR_WDATA[5])
         && fall_irq_en_r == $past(I_SFR_WDATA[4])
         && O_RESPONSE_SPEED_SEL == $past(I_SFR_WDATA[1:0]);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("Mode write not applied.");

   // Mode reads show zero in the unused pairs and the live speed code.
   property p_mode_read;
      @(posedge I_CLOCK) disable iff (I_RST)
      (I_SFR_RD && I_SFR_ADDR == 8'h9D) |=> O_SFR_RDATA[7:6] == 2'h0
         && O_SFR_RDATA[3:2] == 2'h0
         && O_SFR_RDATA[1:0] == $past(O_RESPONSE_SPEED_SEL);
   endproperty
   a_mode_read: assert property (p_mode_read)
      else $error("Mode read image wrong.");

   // Control reads return the synchronised result in bit 6.
   property p_result_read;
      @(posedge I_CLOCK) disable iff (I_RST)
      (I_SFR_RD && I_SFR_ADDR == 8'h9C) |=>
         O_SFR_RDATA[6] == $past(sync2_r);
   endproperty
   a_result_read: assert property (p_result_read)
      else $error("Result bit read wrong.");

   // Any flag whose enable is set raises the request.
   property p_irq;
      @(posedge I_CLOCK) disable iff (I_RST)
      (rise_seen_flag_r && rise_irq_en_r) ||
         (fall_seen_flag_r && fall_irq_en_r) |-> O_IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("Interrupt request missing.");

   // Without any enabled flag the request stays low.
   property p_irq_low;
      @(posedge I_CLOCK) disable iff (I_RST)
      !(rise_seen_flag_r && rise_irq_en_r) &&
         !(fall_seen_flag_r && fall_irq_en_r) |-> !O_IRQ;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("Interrupt request without cause.");

endmodule : cmpc_regs

// ===== tb/cmpc_analog_model.sv
// Behavioural stand-in for the analog comparator core behind the block.
module cmpc_analog_model (
   input wire logic i_on,
   input wire logic i_level,
   output logic o_result
);
   timeunit 1ns;
   timeprecision 100ps;

   // A core that is switched off holds its output low, so turning it off
   // while the input is high looks like a falling edge to the block.
   assign o_result = i_on ? i_level : 1'b0;
endmodule : cmpc_analog_model

// ===== tb/cmpc_regs_tb.sv
`include "cmpc_params.svh"

module cmpc_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk;
   logic rst;
   logic [7:0] addr;
   logic wr;
   logic rd;
   logic [7:0] wdata;
   logic level;
   logic raw;
   logic [7:0] rdata;
   logic cmp_on;
   logic [1:0] pos_sel;
   logic [1:0] neg_sel;
   logic [1:0] speed_sel;
   logic irq;
   int n_fail;
   int tests_run;

   cmpc_regs DUT (.I_CLOCK(clk), .I_RST(rst), .I_SFR_ADDR(addr),
      .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata),
      .I_CMP_RAW(raw), .O_SFR_RDATA(rdata), .O_CMP_ON(cmp_on),
      .O_POS_HYST_SEL(pos_sel), .O_NEG_HYST_SEL(neg_sel),
      .O_RESPONSE_SPEED_SEL(speed_sel), .O_IRQ(irq));

   cmpc_analog_model core (.i_on(cmp_on), .i_level(level), .o_result(raw));

   // Clock at 40 MHz.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Ends the run with the verdict; used by the tests and the watchdog.
   task automatic print_verdict;
      if (n_fail == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // Compares one 8-bit result and counts it.
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // One write strobe; inputs move 2 ns after the edge. An idle edge
   // follows so that a second call never re-raises the strobe at once.
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #2 wr = 1'b0;
      @(posedge clk);
      #2;
   endtask : sfr_wr

   // One read strobe; data is registered at the taking edge.
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #2 rd = 1'b0;
      chk("read data", exp, rdata);
      @(posedge clk);
      #2;
   endtask : sfr_rd

   // Lets the synchroniser and flag stage settle after an input change.
   task automatic settle;
      repeat (5) @(posedge clk);
      #2;
   endtask : settle

   // Watchdog sized well above the length of the sequence below.
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      print_verdict();
   end

   initial begin
      n_fail = 0;
      tests_run = 0;
      rst = 1'b1;
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
      level = 1'b0;
      repeat (12) @(posedge clk);
      #2 rst = 1'b0;
      // Reset images and outputs.
      chk("speed", 8'h02, {6'h00, speed_sel});
      sfr_rd(`CMPC_CTRL_ADDR, 8'h00);
      sfr_rd(`CMPC_MODE_ADDR, 8'h02);
      // Enable, max hysteresis; the result bit write is ignored.
      sfr_wr(`CMPC_CTRL_ADDR, 8'hCF);
      chk("config", 8'h1F, {3'h0, cmp_on, pos_sel, neg_sel});
      sfr_rd(`CMPC_CTRL_ADDR, 8'h8F);
      sfr_wr(`CMPC_CTRL_ADDR, 8'h86);
      chk("config", 8'h16, {3'h0, cmp_on, pos_sel, neg_sel});
      // Unused mode bits read back as zero.
      sfr_wr(`CMPC_MODE_ADDR, 8'hFF);
      sfr_rd(`CMPC_MODE_ADDR, 8'h33);
      for (int k = 0; k < 4; k++) begin
         sfr_wr(`CMPC_MODE_ADDR, 8'hCC | 8'(k));
         chk("speed", 8'(k), {6'h00, speed_sel});
         sfr_rd(`CMPC_MODE_ADDR, 8'(k));
      end
      // Rising edge with its interrupt enabled.
      sfr_wr(`CMPC_MODE_ADDR, 8'h20);
      chk("irq", 8'h00, {7'h00, irq});
      level = 1'b1;
      settle();
      chk("irq", 8'h01, {7'h00, irq});
      sfr_rd(`CMPC_CTRL_ADDR, 8'hE6);
      // Only the falling enable: rising flag alone must not interrupt.
      sfr_wr(`CMPC_MODE_ADDR, 8'h10);
      chk("irq", 8'h00, {7'h00, irq});
      level = 1'b0;
      settle();
      chk("irq", 8'h01, {7'h00, irq});
      sfr_rd(`CMPC_CTRL_ADDR, 8'hB6);
      // Software clears both flags.
      sfr_wr(`CMPC_CTRL_ADDR, 8'h86);
      sfr_rd(`CMPC_CTRL_ADDR, 8'h86);
      chk("irq", 8'h00, {7'h00, irq});
      // Unmapped address: write ignored, reads zero.
      sfr_wr(8'h9E, 8'hFF);
      sfr_rd(8'h9E, 8'h00);
      sfr_rd(`CMPC_CTRL_ADDR, 8'h86);
      sfr_wr(`CMPC_CTRL_ADDR, 8'h06);
      chk("config", 8'h06, {3'h0, cmp_on, pos_sel, neg_sel});
      print_verdict();
   end
endmodule : cmpc_regs_tb
